// [rcpm_axil.sv]
// axi4-lite slave front end producing one-cycle read and write strobes
`timescale 1ns/1ps
module rcpm_axil #(
  parameter int ADDR_W = 12
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // write address and data
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // read address and data
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // register side
  output logic wr_stb,
  output logic [ADDR_W-1:0] wr_addr,
  output logic [7:0] wr_data,
  input wire logic wr_ok,
  output logic rd_stb,
  output logic [ADDR_W-1:0] rd_addr,
  input wire logic [7:0] rd_data,
  input wire logic rd_ok
);
  import rcpm_pkg::*;

  logic aw_held_reg;
  logic w_held_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [7:0] wdata_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  // the register map needs the full package address width
  if (ADDR_W < RCPM_ADDR_W) begin : g_addr_w_check
    $error("address width too small for the register map");
  end

  // accept channels while no response is pending
  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready = !w_held_reg && !bvalid_reg;
  assign s_axi_arready = !rvalid_reg;
  wire aw_fire = s_axi_awvalid && s_axi_awready;
  wire w_fire = s_axi_wvalid && s_axi_wready;
  wire aw_have = aw_held_reg || aw_fire;
  wire w_have = w_held_reg || w_fire;
  assign wr_stb = aw_have && w_have && !bvalid_reg;
  assign wr_addr = aw_held_reg ? awaddr_reg : s_axi_awaddr;
  assign wr_data = w_held_reg ? wdata_reg :
                   (s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00);
  assign rd_stb = s_axi_arvalid && s_axi_arready;
  assign rd_addr = s_axi_araddr;

  // write side holding and response
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= 8'h00;
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'b00;
    end else if (wr_stb) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_ok ? RCPM_RESP_OKAY : RCPM_RESP_SLVERR;
    end else begin
      if (aw_fire) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (w_fire) begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
      end
      if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // read response, data registered
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= 2'b00;
    end else if (rd_stb) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= {24'h00_0000, rd_data};
      rresp_reg <= rd_ok ? RCPM_RESP_OKAY : RCPM_RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
endmodule : rcpm_axil

// [rcpm_checker.sv]
// concurrent checks on the ports of the reset cause and power mode block
`timescale 1ns/1ps
module rcpm_checker
  import rcpm_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // events and options
  input wire logic por_event,
  input wire logic wdog_timeout,
  input wire logic pin_reset_event,
  input wire logic dbg_reset_event,
  input wire logic debug_wire_pin_reset,
  input wire logic pin_change_wake,
  input wire logic idle_instr,
  input wire logic irq_pending,
  input wire logic brownout_reset,
  input wire logic brownout_keepalive_option,
  input wire logic wdog_enable,
  // read channel
  input wire logic [RCPM_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  // clock and power controls
  input wire logic main_osc_run,
  input wire logic sys_clk_run,
  input wire logic cpu_run,
  input wire logic wdog_osc_run,
  input wire logic periph_clk_run,
  input wire logic xtal_pins_to_port,
  input wire logic brownout_enable,
  input wire logic ipo_force_select,
  input wire logic cpu_reset_hold
);
  logic [RCPM_ADDR_W-1:0] rd_addr_reg;
  logic any_rst;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // address of the read in flight, and any reset-like event
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) rd_addr_reg <= '0;
    else if (s_axi_arvalid && s_axi_arready) rd_addr_reg <= s_axi_araddr;
  end
  assign any_rst = por_event | wdog_timeout | pin_reset_event | dbg_reset_event | brownout_reset;
  // properties
  property p_low_bits_zero;
    s_axi_rvalid && rd_addr_reg == RCPM_CAUSE_ADDR |-> s_axi_rdata[3:0] == 4'h0;
  endproperty
  a_low_bits_zero: assert property (p_low_bits_zero) else $error("cause low bits set");
  property p_bod_keep;
    brownout_keepalive_option |-> brownout_enable;
  endproperty
  a_bod_keep: assert property (p_bod_keep) else $error("brownout off with keepalive");
  property p_bod_sleep;
    !sys_clk_run && !brownout_keepalive_option |-> !brownout_enable;
  endproperty
  a_bod_sleep: assert property (p_bod_sleep) else $error("brownout on in sleep");
  property p_sleep_stop;
    !sys_clk_run |-> !main_osc_run && !cpu_run && !periph_clk_run && xtal_pins_to_port;
  endproperty
  a_sleep_stop: assert property (p_sleep_stop) else $error("sleep controls wrong");
  property p_wdog_osc;
    wdog_osc_run == wdog_enable;
  endproperty
  a_wdog_osc: assert property (p_wdog_osc) else $error("watchdog osc mismatch");
  property p_idle_enter;
    idle_instr && cpu_run && !any_rst |=> !cpu_run && sys_clk_run && periph_clk_run;
  endproperty
  a_idle_enter: assert property (p_idle_enter) else $error("idle entry wrong");
  property p_idle_exit;
    irq_pending && sys_clk_run && !cpu_run |=> cpu_run;
  endproperty
  a_idle_exit: assert property (p_idle_exit) else $error("idle not left");
  property p_sleep_hold;
    !sys_clk_run && !(any_rst | debug_wire_pin_reset | pin_change_wake) |=> !sys_clk_run;
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("sleep left early");
  property p_recover_ipo;
    !sys_clk_run && pin_change_wake && !any_rst && !debug_wire_pin_reset
      |-> ##[1:2] ipo_force_select && cpu_reset_hold;
  endproperty
  a_recover_ipo: assert property (p_recover_ipo) else $error("no oscillator reselect");
endmodule : rcpm_checker

// [rcpm_pkg.sv]
// package: register map, field positions, reset values and modes of the reset cause block
package rcpm_pkg;
  // register byte addresses
  localparam logic [11:0] RCPM_PWR_CTRL_ADDR = 12'hf80;
  localparam logic [11:0] RCPM_CAUSE_ADDR = 12'hff0;
  localparam logic [11:0] RCPM_MODE_ADDR = 12'hf84;
  localparam int RCPM_ADDR_W = 12;
  // reset cause field positions
  localparam int RCPM_POR_BIT = 7;
  localparam int RCPM_SLEEP_BIT = 6;
  localparam int RCPM_WDOG_BIT = 5;
  localparam int RCPM_PIN_BIT = 4;
  // power control field positions and reset value
  localparam int RCPM_BOD_BIT = 4;
  localparam int RCPM_CMP_BIT = 1;
  localparam logic [7:0] RCPM_PWR_CTRL_RESET = 8'h88;
  localparam logic [7:0] RCPM_PWR_CTRL_MASK = 8'hff;
  // reset cause after power-on
  localparam logic [7:0] RCPM_CAUSE_POR_VALUE = 8'h80;
  // mode register layout: bit 1 deep sleep, bit 0 idle
  localparam int RCPM_MODE_SLEEP_BIT = 1;
  localparam int RCPM_MODE_IDLE_BIT = 0;
  // axi responses
  localparam logic [1:0] RCPM_RESP_OKAY = 2'b00;
  localparam logic [1:0] RCPM_RESP_SLVERR = 2'b10;
  // power modes
  typedef enum logic [1:0] {
    RCPM_RUN,
    RCPM_IDLE,
    RCPM_SLEEP
  } rcpm_mode_t;
endpackage : rcpm_pkg

// [rcpm_sync.sv]
// reset release synchroniser
`timescale 1ns/1ps
module rcpm_sync (
  // clock and raw reset
  input wire logic core_clk,
  input wire logic nrst,
  // released reset
  output logic rst_sync_n
);
  logic stage1_reg;
  logic stage2_reg;

  // two flops, asynchronous assert, synchronous release
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      stage1_reg <= 1'b0;
      stage2_reg <= 1'b0;
    end else begin
      stage1_reg <= 1'b1;
      stage2_reg <= stage1_reg;
    end
  end

  assign rst_sync_n = stage2_reg;
endmodule : rcpm_sync

// [rcpm_top.sv]
// reset cause recording, power modes and peripheral power control
// Function
// [R1] reading cause register clears top four flags
// [R2] cause reads and watchdog writes share address
// [R3] power-on flag: set by POR, cleared otherwise
// [R4] sleep flag: set on recovery, cleared otherwise
// [R5] watchdog recovery sets sleep and watchdog flags
// [R6] watchdog flag: set on timeout, cleared otherwise
// [R7] software reads cause before clearing watchdog interrupt
// [R8] pin flag: set by reset pin
// [R9] low four cause bits read zero
// [R10] debugger and debug-pin resets leave power-on only
// [R11] deep sleep stops oscillators, clock and processor
// [R12] deep sleep releases crystal pins to port
// [R13] brown-out runs in sleep only with keep-alive
// [R14] deep sleep exits only through recovery; here reset class events end it too
// [R15] idle stops processor, clocks keep running
// [R16] idle exits on interrupt, timeout or reset
// [R17] disable bits gate peripheral clock
// [R18] power control reset only by power-on
// [R19] brown-out disable bit honoured without keep-alive
// [R20] comparator disable bit
// [R21] software writes fixed values to reserved bits
// [R22] recovery re-selects precision oscillator
// [R23] cause event beats a same-cycle clearing read
`timescale 1ns/1ps
module rcpm_top (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,

  // reset and recovery events, one-cycle pulses
  input wire logic por_event,
  input wire logic wdog_timeout,
  input wire logic pin_reset_event,
  input wire logic dbg_reset_event,
  input wire logic debug_wire_pin_reset,
  input wire logic pin_change_wake,

  // processor mode requests and wake sources
  input wire logic sleep_instr,
  input wire logic idle_instr,
  input wire logic irq_pending,
  input wire logic brownout_reset,

  // option bits and enables
  input wire logic brownout_keepalive_option,
  input wire logic wdog_enable,

  // axi4-lite write address and data
  input wire logic [rcpm_pkg::RCPM_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,

  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,

  // axi4-lite read
  input wire logic [rcpm_pkg::RCPM_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,

  // watchdog control write port
  output logic wdog_ctrl_wr,
  output logic [7:0] wdog_ctrl_data,

  // clock and power controls
  output logic main_osc_run,
  output logic sys_clk_run,
  output logic cpu_run,
  output logic wdog_osc_run,
  output logic periph_clk_run,
  output logic xtal_pins_to_port,
  output logic brownout_enable,
  output logic comparator_clk_en,
  output logic ipo_force_select,
  output logic cpu_reset_hold
);
  import rcpm_pkg::*;

  // released reset
  logic rst_n;

  // register side of the bus front end
  logic wr_stb;
  logic [RCPM_ADDR_W-1:0] wr_addr;
  logic [7:0] wr_data;
  logic rd_stb;
  logic [RCPM_ADDR_W-1:0] rd_addr;
  logic [7:0] rd_data;
  logic rd_ok;
  logic wr_ok;

  // reset cause flags, bits 7 to 4 of the status view
  logic [3:0] flags_reg;
  logic [3:0] flags_next;

  // power control register
  logic [7:0] pwr_ctrl_reg;
  logic [7:0] pwr_ctrl_next;

  // power mode and recovery pulse
  rcpm_mode_t mode_reg;
  rcpm_mode_t mode_next;
  logic recov_reg;

  // watchdog control write port
  logic wdog_ctrl_wr_reg;
  logic [7:0] wdog_ctrl_data_reg;

  // reset release; every register below resets on the released copy
  rcpm_sync u_sync (
    .core_clk(core_clk),
    .nrst(nrst),
    .rst_sync_n(rst_n)
  );

  // bus front end
  // one write and one read may be in flight at a time
  rcpm_axil #(
    .ADDR_W(RCPM_ADDR_W)
  ) u_axil (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_stb(wr_stb),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_ok(wr_ok),
    .rd_stb(rd_stb),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
  );

  // register selection, shared by read and write decode
  function automatic logic sel_cause(input logic [RCPM_ADDR_W-1:0] a);
    sel_cause = a == RCPM_CAUSE_ADDR;
  endfunction : sel_cause

  function automatic logic sel_pwr(input logic [RCPM_ADDR_W-1:0] a);
    sel_pwr = a == RCPM_PWR_CTRL_ADDR;
  endfunction : sel_pwr

  function automatic logic sel_mode(input logic [RCPM_ADDR_W-1:0] a);
    sel_mode = a == RCPM_MODE_ADDR;
  endfunction : sel_mode

  // address decode; the cause address reads status and writes watchdog control
  // anything outside the map gets an error response
  wire rd_sel_cause = sel_cause(rd_addr);
  wire rd_cause = rd_stb && rd_sel_cause;
  wire rd_pwr = sel_pwr(rd_addr);
  wire rd_mode = sel_mode(rd_addr);
  wire wr_sel_cause = sel_cause(wr_addr);
  wire wr_sel_pwr = sel_pwr(wr_addr);
  wire wr_wdog = wr_stb && wr_sel_cause; // R2
  wire wr_pwr = wr_stb && wr_sel_pwr;
  assign wr_ok = wr_sel_cause || wr_sel_pwr;
  assign rd_ok = rd_sel_cause || rd_pwr || rd_mode;

  // register views; reserved cause bits always read zero
  wire [7:0] cause_view = {flags_reg, 4'h0}; // R9
  wire [7:0] pwr_view = pwr_ctrl_reg;
  wire [7:0] mode_view = {6'h00, mode_reg == RCPM_SLEEP, mode_reg == RCPM_IDLE};

  // read mux; unmapped addresses read zero
  assign rd_data = rd_sel_cause ? cause_view : // R2
                   rd_pwr ? pwr_view :
                   rd_mode ? mode_view : 8'h00;

  // event classification
  // the debug pin only resets the device while it sleeps
  // watchdog and pin-change events outside sleep are no recoveries
  // any sleep recovery also raises the recovery pulse
  wire in_sleep = mode_reg == RCPM_SLEEP;
  wire por_like = por_event || dbg_reset_event || (debug_wire_pin_reset && in_sleep);
  wire wdog_recov = wdog_timeout && in_sleep;
  wire pin_recov = pin_change_wake && in_sleep;
  wire sleep_recov = wdog_recov || pin_recov;

  // next cause flags; events applied after the read clear so they win
  // the read returns the old value at the accept edge, the clear lands on it
  // priority: power-on class, reset pin, watchdog recovery, pin recovery, watchdog
  always_comb begin
    flags_next = flags_reg;
    // a read clears all four flags
    if (rd_cause) begin
      flags_next = 4'h0; // R1 R23
    end
    // one event wins; lower priority events that cycle are dropped
    if (por_like) begin
      flags_next = 4'b1000; // R3 R10
    end else if (pin_reset_event) begin
      flags_next = 4'b0001; // R8
    end else if (wdog_recov) begin
      flags_next = 4'b0110; // R5 R6 R4
    end else if (pin_recov) begin
      flags_next = 4'b0100; // R4 R6 R8 R3
    end else if (wdog_timeout) begin
      flags_next = 4'b0010; // R6 R4 R3
    end
  end

  // cause flags, power-on value at reset
  // nrst counts as a power-on, so the flags start as after one
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_reg <= RCPM_CAUSE_POR_VALUE[7:4];
    end else begin
      flags_reg <= flags_next;
    end
  end

  // power control: only por_event reinitialises it, not the other power-on class events
  // a write on the same edge as a power-on reload is lost, the reload wins
  always_comb begin
    pwr_ctrl_next = pwr_ctrl_reg;
    if (por_event) begin
      pwr_ctrl_next = RCPM_PWR_CTRL_RESET; // R18
    end else if (wr_pwr) begin
      pwr_ctrl_next = wr_data & RCPM_PWR_CTRL_MASK;
    end
  end

  // power control register; other reset events leave it alone
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_ctrl_reg <= RCPM_PWR_CTRL_RESET; // R18
    end else begin
      pwr_ctrl_reg <= pwr_ctrl_next;
    end
  end

  // power mode sequencing
  // reset class events end idle and deep sleep alike
  wire any_reset = por_like || pin_reset_event || brownout_reset;
  // idle and sleep are entered only from run
  always_comb begin
    mode_next = mode_reg;
    unique case (mode_reg)
      RCPM_RUN: begin
        // sleep beats idle when both are requested together
        if (sleep_instr) begin
          mode_next = RCPM_SLEEP;
        end else if (idle_instr) begin
          mode_next = RCPM_IDLE;
        end
      end
      RCPM_IDLE: begin
        if (irq_pending || wdog_timeout || any_reset) begin
          mode_next = RCPM_RUN; // R16
        end
      end
      RCPM_SLEEP: begin
        // interrupts alone do not end deep sleep
        if (sleep_recov || any_reset) begin
          mode_next = RCPM_RUN; // R14
        end
      end
    endcase
  end

  // mode state and a recovery pulse one cycle after the wake
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= RCPM_RUN;
      recov_reg <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      recov_reg <= sleep_recov; // R22
    end
  end

  // watchdog control write strobe and data
  // pulse follows the accepted write by one cycle; data holds until the next one
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wdog_ctrl_wr_reg <= 1'b0;
      wdog_ctrl_data_reg <= 8'h00;
    end else begin
      wdog_ctrl_wr_reg <= wr_wdog; // R2
      if (wr_wdog) begin
        wdog_ctrl_data_reg <= wr_data;
      end
    end
  end
  assign wdog_ctrl_wr = wdog_ctrl_wr_reg;
  assign wdog_ctrl_data = wdog_ctrl_data_reg;

  // clock and power outputs per mode
  wire sleeping = mode_reg == RCPM_SLEEP;

  // main oscillator and system clock stop only in deep sleep
  assign main_osc_run = !sleeping; // R11
  assign sys_clk_run = !sleeping; // R11 R15

  // processor stops in idle and in deep sleep
  assign cpu_run = mode_reg == RCPM_RUN; // R11 R15

  // watchdog oscillator follows its enable in every mode
  assign wdog_osc_run = wdog_enable; // R11 R15

  // peripherals go idle in deep sleep, keep running in idle
  assign periph_clk_run = !sleeping; // R11 R15

  // crystal pins return to the port while asleep
  assign xtal_pins_to_port = sleeping; // R12

  // keep-alive overrides both deep sleep and the disable bit
  assign brownout_enable = brownout_keepalive_option ||
                           (!sleeping && !pwr_ctrl_reg[RCPM_BOD_BIT]); // R13 R19 R17

  // comparator clock gated by its disable bit
  assign comparator_clk_en = !pwr_ctrl_reg[RCPM_CMP_BIT]; // R20 R17

  // recovery pulse: cpu held, precision oscillator reselected
  assign ipo_force_select = recov_reg; // R22
  assign cpu_reset_hold = recov_reg;
endmodule : rcpm_top

// [tb_top.sv]
// self-checking bench for the reset cause and power mode block
`timescale 1ns/1ps
module tb_top;
  import rcpm_pkg::*;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [9:0] ev = '0;
  logic por_event, wdog_timeout, pin_reset_event, dbg_reset_event, debug_wire_pin_reset;
  logic pin_change_wake, sleep_instr, idle_instr, brownout_reset, irq_pending;
  logic brownout_keepalive_option = 1'b0;
  logic wdog_enable = 1'b0;
  logic [11:0] s_axi_awaddr = '0;
  logic [11:0] s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [7:0] wdog_ctrl_data;
  logic wdog_ctrl_wr, main_osc_run, sys_clk_run, cpu_run, wdog_osc_run, periph_clk_run;
  logic xtal_pins_to_port, brownout_enable, comparator_clk_en, ipo_force_select, cpu_reset_hold;
  int error_cnt = 0;
  int total_checks = 0;
  int seed = 32'h5ab7;
  int mode = 0;
  int flags = 8;
  int pwr = 'h88;
  // event pulses
  assign {irq_pending, brownout_reset, idle_instr, sleep_instr, pin_change_wake,
    debug_wire_pin_reset, dbg_reset_event, pin_reset_event, wdog_timeout, por_event} = ev;
  always #4 core_clk = ~core_clk;
  rcpm_top dut (.*);
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic finish_test;
    if (error_cnt == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test
  // one write, both channels offered together
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w, b;
    int n;
    b = 1'b0;
    n = 0;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!b && n < 40) begin
      @(negedge core_clk);
      aw = s_axi_awvalid & s_axi_awready;
      w = s_axi_wvalid & s_axi_wready;
      b = s_axi_bvalid;
      if (b) begin
        chk("bresp", er, s_axi_bresp);
        chk("wdog_wr", a == RCPM_CAUSE_ADDR, wdog_ctrl_wr);
        if (a == RCPM_CAUSE_ADDR) chk("wdog_data", d[7:0], wdog_ctrl_data);
      end
      @(posedge core_clk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (b) s_axi_bready <= 1'b0;
      n++;
    end
    if (!b) chk("bvalid", 1, b);
  endtask : wr
  // one read
  task automatic rd(input logic [11:0] a, input logic [1:0] er, output logic [31:0] q);
    logic ar, r;
    int n;
    r = 1'b0;
    n = 0;
    q = '0;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!r && n < 40) begin
      @(negedge core_clk);
      ar = s_axi_arvalid & s_axi_arready;
      r = s_axi_rvalid;
      if (r) begin
        q = s_axi_rdata;
        chk("rresp", er, s_axi_rresp);
      end
      @(posedge core_clk);
      if (ar) s_axi_arvalid <= 1'b0;
      if (r) s_axi_rready <= 1'b0;
      n++;
    end
    if (!r) chk("rvalid", 1, r);
  endtask : rd
  task automatic pulse(input int i);
    @(posedge core_clk);
    ev[i] <= 1'b1;
    @(posedge core_clk);
    ev <= '0;
  endtask : pulse
  // event plus model update and control checks
  task automatic hit(input int i);
    pulse(i);
    case (i)
      0: begin flags = 8; pwr = 'h88; mode = 0; end
      1: begin flags = (mode == 2) ? 6 : 2; mode = 0; end
      2: begin flags = 1; mode = 0; end
      3: begin flags = 8; mode = 0; end
      4: if (mode == 2) begin flags = 8; mode = 0; end
      5: if (mode == 2) begin flags = 4; mode = 0; end
      6: if (mode == 0) mode = 2;
      7: if (mode == 0) mode = 1;
      8: mode = 0;
      default: if (mode == 1) mode = 0;
    endcase
    @(negedge core_clk);
    chk("cpu_run", mode == 0, cpu_run);
    chk("sys_clk", mode != 2, sys_clk_run);
    chk("bod_en", brownout_keepalive_option | (mode != 2 && !pwr[4]), brownout_enable);
    chk("cmp_en", !pwr[1], comparator_clk_en);
  endtask : hit
  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    finish_test;
  end
  initial begin
    logic [31:0] q;
    logic [7:0] v;
    int i;
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge core_clk);
    rd(RCPM_CAUSE_ADDR, RCPM_RESP_OKAY, q);
    chk("cause", 'h80, q);
    rd(RCPM_CAUSE_ADDR, RCPM_RESP_OKAY, q);
    chk("cause", 0, q);
    rd(RCPM_PWR_CTRL_ADDR, RCPM_RESP_OKAY, q);
    chk("pwr", 'h88, q);
    rd(12'h100, RCPM_RESP_SLVERR, q);
    chk("unmapped", 0, q);
    wr(RCPM_MODE_ADDR, 0, RCPM_RESP_SLVERR);
    wr(RCPM_CAUSE_ADDR, $random(seed), RCPM_RESP_OKAY);
    hit(2);
    // event lands on the edge that takes the read
    fork
      rd(RCPM_CAUSE_ADDR, RCPM_RESP_OKAY, q);
      pulse(1);
    join
    chk("cause", 'h10, q);
    rd(RCPM_CAUSE_ADDR, RCPM_RESP_OKAY, q);
    chk("cause", 'h20, q);
    flags = 0;
    for (int k = 0; k < 300; k++) begin
      i = ($random(seed) & 32'hffff) % 10;
      brownout_keepalive_option <= 1'($random(seed));
      wdog_enable <= 1'($random(seed));
      hit(i);
      if (($random(seed) & 7) == 0) begin
        rd(RCPM_MODE_ADDR, RCPM_RESP_OKAY, q);
        chk("mode", {30'h0, mode == 2, mode == 1}, q);
      end
      if (mode == 0 && $random(seed) & 1) begin
        rd(RCPM_CAUSE_ADDR, RCPM_RESP_OKAY, q);
        chk("cause", flags << 4, q);
        flags = 0;
      end
      if (mode == 0 && ($random(seed) & 3) == 0) begin
        v = 8'(($random(seed) & 8'hf2) | 8'h08);
        wr(RCPM_PWR_CTRL_ADDR, v, RCPM_RESP_OKAY);
        pwr = v;
        rd(RCPM_PWR_CTRL_ADDR, RCPM_RESP_OKAY, q);
        chk("pwr", pwr, q);
      end
    end
    finish_test;
  end
endmodule : tb_top
bind rcpm_top rcpm_checker u_chk (.*);
